// ===== core/umsf_pkg.sv
// Purpose: shared constants and types of the serial channel status block
// Assumes: one channel per instance, 125 MHz sys_clk
// Notes: receiver clock runs at sixteen times the bit rate
`default_nettype none

package umsf_pkg;
   // ------------------------------------------------
   // register offsets
   // ------------------------------------------------
   localparam logic [2:0] OFF_DATA = 3'h0;
   localparam logic [2:0] OFF_IER = 3'h1;
   localparam logic [2:0] OFF_IIR = 3'h2;
   localparam logic [2:0] OFF_LCR = 3'h3;
   localparam logic [2:0] OFF_MCR = 3'h4;
   localparam logic [2:0] OFF_LSR = 3'h5;
   localparam logic [2:0] OFF_MSR = 3'h6;
   localparam logic [2:0] OFF_SCR = 3'h7;
   // ------------------------------------------------
   // field positions
   // ------------------------------------------------
   localparam int IER_RX = 0;
   localparam int IER_TX = 1;
   localparam int IER_LS = 2;
   localparam int IER_MS = 3;
   localparam int FCR_EN = 0;
   localparam int FCR_RXCLR = 1;
   localparam int FCR_TXCLR = 2;
   localparam int LCR_STB = 2;
   localparam int LCR_PEN = 3;
   localparam int MCR_LOOP = 4;
   // ------------------------------------------------
   // identification codes and trigger levels
   // ------------------------------------------------
   localparam logic [3:0] ID_NONE = 4'h1;
   localparam logic [3:0] ID_RLS = 4'h6;
   localparam logic [3:0] ID_RDA = 4'h4;
   localparam logic [3:0] ID_CTO = 4'hC;
   localparam logic [3:0] ID_TX_HOLDING_EMPTY = 4'h2;
   localparam logic [3:0] ID_MS = 4'h0;
   localparam logic [4:0] TRIG_01 = 5'h01;
   localparam logic [4:0] TRIG_04 = 5'h04;
   localparam logic [4:0] TRIG_08 = 5'h08;
   localparam logic [4:0] TRIG_14 = 5'h0E;
   // ------------------------------------------------
   // sizes, counts and reset values
   // ------------------------------------------------
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam int RX_W = 11;
   localparam int TX_W = 8;
   localparam logic [4:0] FIFO_FULL = 5'h10;
   localparam logic [9:0] TICKS_PER_BIT = 10'h010;
   localparam logic [9:0] TIMEOUT_CHARS = 10'h004;
   localparam logic [3:0] CHAR_BITS_MIN = 4'h7;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [18:0] PIN_IDLE = 19'h7FFFF;
   typedef enum logic [2:0] {
      TH_BUSY = 3'b001,
      TH_WAIT = 3'b010,
      TH_EMPTY = 3'b100
   } umsf_tx_holding_empty_type;
endpackage

`default_nettype wire

// ===== core/umsf_fifo_if.sv
// Purpose: queue connection between the channel core and its fifos
// Assumes: push and pop are one-cycle requests
// Notes: owner drives requests, store answers with state
`default_nettype none

interface umsf_fifo_if #(parameter int W = 8);
   import umsf_pkg::*;
   logic push;
   logic pop;
   logic clear;
   logic full;
   logic empty;
   logic [W-1:0] pushData;
   logic [W-1:0] popData;
   logic [CNT_W-1:0] count;
   modport owner(output push, pop, clear, pushData, input popData, count, full, empty);
   modport store(input push, pop, clear, pushData, output popData, count, full, empty);
endinterface

`default_nettype wire

// ===== core/umsf_fifo.sv
// Purpose: sixteen entry character queue
// Assumes: push when full and pop when empty are ignored
// Notes: clear wins over push and pop
`default_nettype none

module umsf_fifo #(parameter int W = 8) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // queue port
   umsf_fifo_if.store q
);
   import umsf_pkg::*;

   logic [W-1:0] mem [FIFO_DEPTH];
   logic [PTR_W-1:0] wrPtr;
   logic [PTR_W-1:0] rdPtr;
   logic [CNT_W-1:0] count;
   logic doPush;
   logic doPop;

   assign doPush = q.push & (count != FIFO_FULL);
   assign doPop = q.pop & (count != '0);

   always_ff @(posedge sys_clk) begin
      if (doPush) begin
         mem[wrPtr] <= q.pushData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || q.clear) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doPush) begin
            wrPtr <= wrPtr + PTR_W'(1);
         end
         if (doPop) begin
            rdPtr <= rdPtr + PTR_W'(1);
         end
         count <= count + CNT_W'(doPush) - CNT_W'(doPop);
      end
   end

   assign q.popData = mem[rdPtr];
   assign q.count = count;
   assign q.full = (count == FIFO_FULL);
   assign q.empty = (count == '0);
endmodule

`default_nettype wire

// ===== core/umsf_core.sv
// Purpose: one serial channel: modem status, fifo interrupts, line status
// Assumes: host strobes and modem pins are asynchronous; shift logic is local
// Notes: baud generator and serial shifters live outside this block
//
// Notes on behaviour
// - change bits set on toggle, cleared by read
// - bit0 cts, bit1 dsr, bit3 carrier change
// - bit2 only on ring pin rising
// - any change bit plus enable raises interrupt
// - bits 4..7 show inverted modem pins
// - loop mode shows control bits instead
// - receive interrupt follows fill versus trigger
// - line status beats received data
// - data ready set on push, clear empty
// - timeout after four idle character times
// - second stop bit counts in timeout
// - character time counted in receiver clocks
// - pending timeout cleared by one read
// - idle timer restarts on push or read
// - tx empty interrupt, cleared by write/ident
// - single byte empty indication delayed
// - first tx interrupt after mode change immediate
// - timeout shares receive priority, empty shares tx
// - disabled enables give polled operation
// - polled status through line state bits
// - polled mode hides trigger and timeout
// - fcr bits 7:6 select trigger level
// - ier bit0 enables data and timeout
`default_nettype none

module umsf_core (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // host register bus pins
   input wire logic csN,
   input wire logic iorN,
   input wire logic iowN,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] busIn,
   output logic [7:0] busOut,
   output logic busOeN,
   // modem pins
   input wire logic ctsN,
   input wire logic dsrN,
   input wire logic riN,
   input wire logic rlsdN,
   output logic rtsN,
   output logic dtrN,
   // receiver clock pin
   input wire logic rclk,
   // receive shift path
   input wire logic rxPush,
   input wire logic [7:0] rxChar,
   input wire logic rxParityErr,
   input wire logic rxFrameErr,
   input wire logic rxBreak,
   // transmit shift path
   input wire logic txTake,
   input wire logic txShiftEmpty,
   output logic txValid,
   output logic [7:0] txData,
   // interrupt
   output logic irq
);
   import umsf_pkg::*;

   // ------------------------------------------------
   // declarations
   // ------------------------------------------------
   logic [18:0] syncA;
   logic [18:0] syncB;
   logic [18:0] syncC;
   logic [2:0] cAddr;
   logic [7:0] cData;
   logic rdEnd;
   logic wrEnd;
   logic rclkTick;
   logic rdData;
   logic rdIir;
   logic rdLsr;
   logic rdMsr;
   logic wrData;
   logic wrFcr;
   logic wrIer;
   logic [3:0] ier;
   logic [7:0] lcr;
   logic [4:0] modem_control;
   logic [7:0] scr;
   logic fifoEn;
   logic [1:0] trigSel;
   logic [4:0] trigLevel;
   logic fcrChange;
   logic fcrFresh;
   logic [3:0] lvl;
   logic [3:0] lvlPrev;
   logic [3:0] chg;
   logic [3:0] msrDelta;
   logic headSeen;
   logic [2:0] lsrErr;
   logic ovr;
   logic [CNT_W-1:0] errCount;
   logic [3:0] charBits;
   logic [9:0] charTicks;
   logic [9:0] toLimit;
   logic [9:0] tickCnt;
   logic toPend;
   umsf_tx_holding_empty_type thState;
   logic [9:0] thCnt;
   logic twoSeen;
   logic tx_holding_empty;
   logic threPrev;
   logic threPend;
   logic lsAny;
   logic rdaCond;
   logic [3:0] iirId;
   logic [7:0] lsrValue;
   logic [7:0] readValue;

   umsf_fifo_if #(.W(RX_W)) rxQ ();
   umsf_fifo_if #(.W(TX_W)) txQ ();

   // ------------------------------------------------
   // fifos
   // ------------------------------------------------
   umsf_fifo #(.W(RX_W)) rxFifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .q(rxQ.store)
   );
   umsf_fifo #(.W(TX_W)) txFifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .q(txQ.store)
   );

   // ------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         syncA <= PIN_IDLE;
         syncB <= PIN_IDLE;
         syncC <= PIN_IDLE;
      end else begin
         syncA <= {csN, iorN, iowN, regAddr, busIn, ctsN, dsrN, riN, rlsdN, rclk};
         syncB <= syncA;
         syncC <= syncB;
      end
   end

   assign cAddr = syncC[15:13];
   assign cData = syncC[12:5];
   assign rdEnd = ~syncC[18] & ~syncC[17] & syncB[17];
   assign wrEnd = ~syncC[18] & ~syncC[16] & syncB[16];
   assign rclkTick = syncB[0] & ~syncC[0];
   assign rdData = rdEnd & (cAddr == OFF_DATA);
   assign rdIir = rdEnd & (cAddr == OFF_IIR);
   assign rdLsr = rdEnd & (cAddr == OFF_LSR);
   assign rdMsr = rdEnd & (cAddr == OFF_MSR);
   assign wrData = wrEnd & (cAddr == OFF_DATA);
   assign wrFcr = wrEnd & (cAddr == OFF_IIR);
   assign wrIer = wrEnd & (cAddr == OFF_IER);
   assign fcrChange = wrFcr & (cData[FCR_EN] != fifoEn);

   // ------------------------------------------------
   // control registers
   // ------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ier <= RST_REG[3:0];
         lcr <= RST_REG;
         modem_control <= RST_REG[4:0];
         scr <= RST_REG;
         fifoEn <= 1'b0;
         trigSel <= RST_REG[1:0];
      end else if (wrEnd) begin
         case (cAddr)
            OFF_IER: ier <= cData[3:0];
            OFF_LCR: lcr <= cData;
            OFF_MCR: modem_control <= cData[4:0];
            OFF_SCR: scr <= cData;
            OFF_IIR: begin
               fifoEn <= cData[FCR_EN];
               if (cData[FCR_EN]) begin
                  trigSel <= cData[7:6];
               end
            end
            default: ;
         endcase
      end
   end

   always_comb begin
      case (trigSel)
         2'b00: trigLevel = TRIG_01;
         2'b01: trigLevel = TRIG_04;
         2'b10: trigLevel = TRIG_08;
         default: trigLevel = TRIG_14;
      endcase
   end

   // ------------------------------------------------
   // modem status
   // ------------------------------------------------
   assign lvl = modem_control[MCR_LOOP] ? {modem_control[3], modem_control[2], modem_control[0], modem_control[1]}
                              : ~{syncB[1], syncB[2], syncB[3], syncB[4]};
   assign chg = {lvl[3] ^ lvlPrev[3], lvlPrev[2] & ~lvl[2],
                 lvl[1] ^ lvlPrev[1], lvl[0] ^ lvlPrev[0]};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lvlPrev <= '0;
         msrDelta <= '0;
      end else begin
         lvlPrev <= lvl;
         msrDelta <= (rdMsr ? 4'h0 : msrDelta) | chg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rtsN <= 1'b1;
         dtrN <= 1'b1;
      end else begin
         rtsN <= ~modem_control[1] | modem_control[MCR_LOOP];
         dtrN <= ~modem_control[0] | modem_control[MCR_LOOP];
      end
   end

   // ------------------------------------------------
   // receive queue and line errors
   // ------------------------------------------------
   assign rxQ.push = rxPush & ~rxQ.full;
   assign rxQ.pushData = {rxBreak, rxFrameErr, rxParityErr, rxChar};
   assign rxQ.pop = rdData & ~rxQ.empty;
   assign rxQ.clear = wrFcr & cData[FCR_EN] & cData[FCR_RXCLR];

   always_ff @(posedge sys_clk) begin
      if (rst || rxQ.clear) begin
         headSeen <= 1'b0;
      end else if (rxQ.pop) begin
         headSeen <= 1'b0;
      end else if (!rxQ.empty) begin
         headSeen <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lsrErr <= '0;
         ovr <= 1'b0;
      end else begin
         lsrErr <= (rdLsr ? 3'h0 : lsrErr)
                   | ((~rxQ.empty & ~headSeen) ? rxQ.popData[10:8] : 3'h0);
         ovr <= (rdLsr ? 1'b0 : ovr) | (rxPush & rxQ.full);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || rxQ.clear) begin
         errCount <= '0;
      end else begin
         errCount <= errCount + CNT_W'(rxQ.push & (|rxQ.pushData[10:8]))
                     - CNT_W'(rxQ.pop & (|rxQ.popData[10:8]));
      end
   end

   // ------------------------------------------------
   // character timeout
   // ------------------------------------------------
   assign charBits = CHAR_BITS_MIN + {2'b00, lcr[1:0]} + {3'b000, lcr[LCR_PEN]}
                     + {3'b000, lcr[LCR_STB]};
   assign charTicks = TICKS_PER_BIT * {6'h00, charBits};
   assign toLimit = TIMEOUT_CHARS * charTicks;

   always_ff @(posedge sys_clk) begin
      if (rst || rxQ.clear) begin
         tickCnt <= '0;
         toPend <= 1'b0;
      end else if (rxQ.pop) begin
         tickCnt <= '0;
         toPend <= 1'b0;
      end else if (rxQ.push && !toPend) begin
         tickCnt <= '0;
      end else if (rxQ.empty) begin
         tickCnt <= '0;
      end else if (rclkTick && !toPend) begin
         tickCnt <= tickCnt + 10'h001;
         if (tickCnt >= toLimit - 10'h001) begin
            toPend <= 1'b1;
         end
      end
   end

   // ------------------------------------------------
   // transmit queue and holding empty
   // ------------------------------------------------
   assign txQ.push = wrData & ~txQ.full;
   assign txQ.pushData = cData;
   assign txQ.pop = ~txQ.empty & (~txValid | txTake);
   assign txQ.clear = wrFcr & cData[FCR_EN] & cData[FCR_TXCLR];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         txValid <= 1'b0;
         txData <= RST_REG;
      end else if (txQ.pop) begin
         txValid <= 1'b1;
         txData <= txQ.popData;
      end else if (txTake) begin
         txValid <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || tx_holding_empty) begin
         twoSeen <= 1'b0;
      end else if (txQ.count >= CNT_W'(2)) begin
         twoSeen <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fcrFresh <= 1'b0;
      end else if (fcrChange) begin
         fcrFresh <= 1'b1;
      end else if (threPend) begin
         fcrFresh <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         thState <= TH_EMPTY;
         thCnt <= '0;
      end else begin
         case (thState)
            TH_BUSY: begin
               thCnt <= '0;
               if (txQ.empty) begin
                  if (twoSeen || !fifoEn || fcrFresh) begin
                     thState <= TH_EMPTY;
                  end else begin
                     thState <= TH_WAIT;
                  end
               end
            end
            TH_WAIT: begin
               if (!txQ.empty) begin
                  thState <= TH_BUSY;
               end else if (fcrFresh || thCnt >= charTicks - TICKS_PER_BIT) begin
                  thState <= TH_EMPTY;
               end else if (rclkTick) begin
                  thCnt <= thCnt + 10'h001;
               end
            end
            TH_EMPTY: begin
               if (!txQ.empty) begin
                  thState <= TH_BUSY;
               end
            end
            default: thState <= TH_EMPTY;
         endcase
      end
   end

   assign tx_holding_empty = (thState == TH_EMPTY);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         threPrev <= 1'b1;
         threPend <= 1'b0;
      end else begin
         threPrev <= tx_holding_empty;
         threPend <= (tx_holding_empty & ~threPrev)
                     | (tx_holding_empty & wrIer & cData[IER_TX] & ~ier[IER_TX])
                     | (tx_holding_empty & fcrChange)
                     | (threPend & ~wrData & ~(rdIir & (iirId == ID_TX_HOLDING_EMPTY)));
      end
   end

   // ------------------------------------------------
   // interrupt identification
   // ------------------------------------------------
   assign lsAny = ovr | (|lsrErr);
   assign rdaCond = fifoEn ? (rxQ.count >= trigLevel) : ~rxQ.empty;

   always_comb begin
      iirId = ID_NONE;
      if (ier[IER_LS] && lsAny) begin
         iirId = ID_RLS;
      end else if (ier[IER_RX] && rdaCond) begin
         iirId = ID_RDA;
      end else if (ier[IER_RX] && fifoEn && toPend) begin
         iirId = ID_CTO;
      end else if (ier[IER_TX] && threPend) begin
         iirId = ID_TX_HOLDING_EMPTY;
      end else if (ier[IER_MS] && (|msrDelta)) begin
         iirId = ID_MS;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= (iirId != ID_NONE);
      end
   end

   // ------------------------------------------------
   // read path
   // ------------------------------------------------
   assign lsrValue = {fifoEn & (errCount != '0),
                      tx_holding_empty & ~txValid & txShiftEmpty, tx_holding_empty,
                      lsrErr[2], lsrErr[1], lsrErr[0], ovr,
                      ~rxQ.empty};

   always_comb begin
      case (cAddr)
         OFF_DATA: readValue = rxQ.popData[7:0];
         OFF_IER: readValue = {4'h0, ier};
         OFF_IIR: readValue = {fifoEn, fifoEn, 2'b00, iirId};
         OFF_LCR: readValue = lcr;
         OFF_MCR: readValue = {3'h0, modem_control};
         OFF_LSR: readValue = lsrValue;
         OFF_MSR: readValue = {lvl, msrDelta};
         default: readValue = scr;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         busOut <= RST_REG;
         busOeN <= 1'b1;
      end else begin
         busOut <= readValue;
         busOeN <= syncC[18] | syncC[17];
      end
   end
endmodule

`default_nettype wire

// ===== testbench/umsf_core_asserts.sv
// Purpose: port checks of the serial channel block
// Assumes: one sys_clk domain, rst synchronous active high
// Notes: bus timing follows the three stage strobe synchroniser
`default_nettype none

module umsf_core_asserts (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // host bus
   input wire logic csN,
   input wire logic iorN,
   input wire logic iowN,
   input wire logic [7:0] busOut,
   input wire logic busOeN,
   // modem, transmit and interrupt
   input wire logic rtsN,
   input wire logic dtrN,
   input wire logic txTake,
   input wire logic txValid,
   input wire logic [7:0] txData,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------
   // assertions
   // ------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_reset_quiet: assert property (
      $fell(rst) |-> busOeN && busOut == 8'h00 && !txValid && rtsN && dtrN)
      else $error("outputs not idle after reset");
   a_irq_quiet: assert property ($fell(rst) |-> !irq [*3])
      else $error("irq raised right after reset");
   a_read_drive: assert property ((!csN && !iorN) [*5] |-> !busOeN)
      else $error("read strobe not answered");
   a_oe_cause: assert property (
      !busOeN |-> !$past(iorN, 3) || !$past(iorN, 4) || !$past(iorN, 5))
      else $error("bus driven without read strobe");
   a_oe_release: assert property ($rose(iorN) |-> ##[1:6] busOeN)
      else $error("bus not released after read");
   a_write_quiet: assert property ((iorN && !iowN) [*5] |-> busOeN)
      else $error("bus driven during write");
   a_cs_gate: assert property (csN [*5] |-> busOeN)
      else $error("bus driven while deselected");
   a_tx_hold: assert property (
      txValid && !txTake |=> txValid && $stable(txData))
      else $error("transmit character dropped before take");
endmodule

`default_nettype wire

// ===== testbench/umsf_host.sv
// Purpose: host processor model on the channel register bus
// Assumes: strobe held six cycles, select and address held around it
// Notes: released write data shows the inverse of its last value
`default_nettype none

module umsf_host (
   // clock
   input wire logic sys_clk,
   // register bus
   output logic csN,
   output logic iorN,
   output logic iowN,
   output logic [2:0] regAddr,
   output logic [7:0] busIn,
   input wire logic [7:0] busOut,
   input wire logic busOeN
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------
   // bus cycle
   // ------------------------------------------------
   initial begin
      csN = 1'b1;
      iorN = 1'b1;
      iowN = 1'b1;
      regAddr = 3'h0;
      busIn = 8'hFF;
   end
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge sys_clk);
      csN <= 1'b0;
      regAddr <= a;
      busIn <= d;
      @(posedge sys_clk);
      iowN <= !w;
      iorN <= w;
      repeat (6) @(posedge sys_clk);
      q = busOut;
      iowN <= 1'b1;
      iorN <= 1'b1;
      repeat (4) @(posedge sys_clk);
      csN <= 1'b1;
      busIn <= ~d;
      repeat (4) @(posedge sys_clk);
   endtask
endmodule

`default_nettype wire

// ===== testbench/tb_uart_modem_status_fifo_irq.sv
// Purpose: self-checking bench of the serial channel block
// Assumes: rclk at a quarter of sys_clk, seven bit default character
// Notes: random data from a fixed-seed shift register
`default_nettype none

module tb_uart_modem_status_fifo_irq;
   timeunit 1ns;
   timeprecision 1ns;
   import umsf_pkg::*;
   logic sys_clk, rst, csN, iorN, iowN, busOeN, rtsN, dtrN, txValid, irq;
   logic rxPush, txTake, rclk, txIdle;
   logic [2:0] regAddr, rxErr;
   logic [7:0] busIn, busOut, rxChar, txData, q, c;
   logic [3:0] pinN, np, dl, v;
   logic [1:0] rdiv;
   logic [31:0] lfsr;
   int error_cnt, comparisons, k, j;
   assign rclk = rdiv[1];
   umsf_core u_umsf_core (.sys_clk(sys_clk), .rst(rst), .csN(csN), .iorN(iorN),
      .iowN(iowN), .regAddr(regAddr), .busIn(busIn), .busOut(busOut), .busOeN(busOeN),
      .ctsN(pinN[0]), .dsrN(pinN[1]), .riN(pinN[2]), .rlsdN(pinN[3]), .rtsN(rtsN),
      .dtrN(dtrN), .rclk(rclk), .rxPush(rxPush), .rxChar(rxChar),
      .rxParityErr(rxErr[0]), .rxFrameErr(rxErr[1]), .rxBreak(rxErr[2]), .txTake(txTake),
      .txShiftEmpty(txIdle), .txValid(txValid), .txData(txData), .irq(irq));
   umsf_host u_umsf_host (.sys_clk(sys_clk), .csN(csN), .iorN(iorN), .iowN(iowN),
      .regAddr(regAddr), .busIn(busIn), .busOut(busOut), .busOeN(busOeN));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) rdiv <= rdiv + 2'h1;
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [3:0] dmsr(input logic [3:0] o, input logic [3:0] n);
      return ((o ^ n) & 4'hB) | {1'b0, ~o[2] & n[2], 2'h0};
   endfunction
   function automatic int trig(input int s);
      return (s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 8 : 14;
   endfunction
   function automatic logic [7:0] rv(input int a);
      return (a == 2) ? 8'h01 : (a == 5) ? 8'h60 : 8'h00;
   endfunction
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] x;
      u_umsf_host.acc(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] x);
      u_umsf_host.acc(1'b0, a, 8'h00, x);
   endtask
   task automatic push(input logic [7:0] d, input logic [2:0] e);
      rxChar <= d;
      rxErr <= e;
      rxPush <= 1'b1;
      @(posedge sys_clk);
      rxPush <= 1'b0;
      rxErr <= 3'h0;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic waitirq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      chk("irq wait", {7'h00, irq}, 8'h01);
      if (n >= lim) wrap_up();
   endtask
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      rst = 1'b1;
      pinN = 4'hF;
      rxPush = 1'b0;
      rxErr = 3'h0;
      txIdle = 1'b1;
      rxChar = 8'h00;
      txTake = 1'b0;
      rdiv = 2'h0;
      lfsr = 32'h7d01;
      error_cnt = 0;
      comparisons = 0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      for (k = 1; k < 8; k++) begin
         rd(k[2:0], q);
         chk("reset reg", q, rv(k));
      end
      wr(OFF_IER, 8'h08);
      for (k = 0; k < 8; k++) begin
         lfsr = nxt(lfsr);
         np = (k == 0) ? 4'hB : (k == 1) ? 4'hF : lfsr[3:0];
         dl = dmsr(pinN, np);
         pinN <= np;
         repeat (8) @(posedge sys_clk);
         chk("msr irq", {7'h00, irq}, {7'h00, |dl});
         rd(OFF_MSR, q);
         chk("msr", q, {~np, dl});
         rd(OFF_MSR, q);
         chk("msr again", q, {~np, 4'h0});
         chk("msr irq clear", {7'h00, irq}, 8'h00);
      end
      for (k = 0; k < 4; k++) begin
         lfsr = nxt(lfsr);
         v = lfsr[3:0];
         wr(OFF_MCR, {4'h1, v});
         rd(OFF_MSR, q);
         chk("loop msr", {4'h0, q[7:4]}, {4'h0, v[3], v[2], v[0], v[1]});
         chk("loop pins", {6'h00, rtsN, dtrN}, 8'h03);
      end
      wr(OFF_IER, 8'h01);
      wr(OFF_MCR, 8'h03);
      chk("modem pins", {6'h00, rtsN, dtrN}, 8'h00);
      $display("modem test done");
      for (k = 0; k < 4; k++) begin
         wr(OFF_IIR, {k[1:0], 6'h07});
         lfsr = nxt(lfsr);
         c = lfsr[7:0];
         for (j = 0; j < trig(k) - 1; j++) push(c + j[7:0], 3'h0);
         chk("under trigger", {7'h00, irq}, 8'h00);
         push(c + 8'(trig(k) - 1), 3'h0);
         chk("trigger irq", {7'h00, irq}, 8'h01);
         rd(OFF_IIR, q);
         chk("trigger iir", q, 8'hC4);
         rd(OFF_LSR, q);
         chk("data ready", q & 8'h01, 8'h01);
         rd(OFF_DATA, q);
         chk("rx data", q, c);
         chk("below trigger", {7'h00, irq}, 8'h00);
      end
      $display("trigger test done");
      for (k = 0; k < 2; k++) begin
         wr(OFF_LCR, {5'h00, k[0], 2'h0});
         wr(OFF_IIR, 8'h47);
         lfsr = nxt(lfsr);
         c = lfsr[7:0];
         push(c, 3'h0);
         repeat (1500 + k * 350) @(posedge sys_clk);
         chk("early timeout", {7'h00, irq}, 8'h00);
         waitirq(1000);
         rd(OFF_IIR, q);
         chk("timeout iir", q, 8'hCC);
         rd(OFF_DATA, q);
         chk("timeout data", q, c);
         chk("timeout cleared", {7'h00, irq}, 8'h00);
      end
      wr(OFF_LCR, 8'h00);
      $display("timeout test done");
      wr(OFF_IER, 8'h05);
      wr(OFF_IIR, 8'h07);
      push(c, 3'h7);
      rd(OFF_IIR, q);
      chk("line iir", q, 8'hC6);
      rd(OFF_LSR, q);
      chk("line lsr", q, 8'hFD);
      rd(OFF_IIR, q);
      chk("data iir", q, 8'hC4);
      wr(OFF_IER, 8'h00);
      push(c, 3'h1);
      rd(OFF_IIR, q);
      chk("polled iir", q, 8'hC1);
      chk("polled irq", {7'h00, irq}, 8'h00);
      $display("priority test done");
      wr(OFF_IIR, 8'h07);
      wr(OFF_IER, 8'h02);
      rd(OFF_IIR, q);
      chk("tx_holding_empty first", q, 8'hC2);
      wr(OFF_IIR, 8'h00);
      chk("mode change irq", {7'h00, irq}, 8'h01);
      rd(OFF_IIR, q);
      chk("char iir", q, 8'h02);
      wr(OFF_IIR, 8'h01);
      chk("fifo on irq", {7'h00, irq}, 8'h01);
      rd(OFF_IIR, q);
      chk("tx_holding_empty iir", q, 8'hC2);
      chk("ident clear", {7'h00, irq}, 8'h00);
      lfsr = nxt(lfsr);
      c = lfsr[7:0];
      wr(OFF_DATA, c);
      chk("tx valid", {7'h00, txValid}, 8'h01);
      chk("tx data", txData, c);
      txTake <= 1'b1;
      @(posedge sys_clk);
      txTake <= 1'b0;
      repeat (300) @(posedge sys_clk);
      chk("tx_holding_empty delayed", {7'h00, irq}, 8'h00);
      waitirq(400);
      txIdle <= 1'b0;
      rd(OFF_LSR, q);
      chk("shift busy", q, 8'h20);
      $display("transmit test done");
      wrap_up();
   end
endmodule

bind umsf_core umsf_core_asserts u_umsf_core_asserts (.sys_clk(sys_clk), .rst(rst),
   .csN(csN), .iorN(iorN), .iowN(iowN), .busOut(busOut), .busOeN(busOeN), .rtsN(rtsN),
   .dtrN(dtrN), .txTake(txTake), .txValid(txValid), .txData(txData), .irq(irq));

`default_nettype wire
